// >>> common/ufc_map.svh
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH

// Register byte offsets on APB
`define UFC_OFF_CONTROL   12'h000
`define UFC_OFF_P2_HIGH   12'h004
`define UFC_OFF_P2_LOW    12'h008
`define UFC_OFF_STATUS    12'h00c

// Control register fields
`define UFC_CTL_FLOW_LSB  0
`define UFC_CTL_MODE_LSB  4

// Reset values
`define UFC_RST_CONTROL   8'h00
`define UFC_RST_P2_HIGH   1'b0
`define UFC_RST_P2_LOW    8'h00

// Flow selection codes
`define UFC_FLOW_OFF      2'b00
`define UFC_FLOW_HW       2'b10

// Receive FIFO depth
`define UFC_FIFO_DEPTH    2'd2

`endif

// >>> common/ufc_pkg.sv
package ufc_pkg;

	typedef enum logic [3:0]
	{
		UFC_MODE_ASYNC8   = 4'h0,
		UFC_MODE_ASYNC7   = 4'h1,
		UFC_MODE_ASYNC_P  = 4'h2,
		UFC_MODE_ADDRESS  = 4'h4,
		UFC_MODE_LIN_SLV  = 4'hb,
		UFC_MODE_LIN_MST  = 4'hc,
		UFC_MODE_DMX      = 4'ha,
		UFC_MODE_DALI     = 4'h8
	} ufc_mode_e;

	typedef enum logic [1:0]
	{
		UFC_TX_IDLE = 2'b00,
		UFC_TX_BUSY = 2'b01
	} ufc_tx_state_e;

endpackage

// >>> hdl/ufc_flow_ctrl.sv
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
// What this block does
// - No flow control in LIN, DALI or DMX modes.
// - Hardware or XON/XOFF flow chosen by a two-bit flow select field.
// - Flow select of 00 disables all flow control.
// - Flow select of 10 enables hardware handshake.
// - Acts as DTE: request-to-send output, clear-to-send input, both active low.
// - Line driver enable high only while a character is being sent.
// - Request-to-send asserted low while the receive FIFO is empty.
// - After a receive, request-to-send stays high until FIFO is fully empty.
// - Clear-to-send loss mid-character finishes it, blocks the next one.
// - Second FIFO location accepts a character while request-to-send is high.
// - DMX mode: parameter two is first channel address of receive block.
// - DALI mode: parameter two is idle threshold in half-bit periods.
// - Address mode: low byte is own address; LIN slave mode uses the low byte as transmit byte count.
`include "ufc_map.svh"

module ufc_flow_ctrl
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cts_n_pin,
	output logic             rts_n,
	output logic             line_driver_enable,
	input  wire logic        tx_char_pending,
	input  wire logic        tx_char_done,
	output logic             tx_char_start,
	input  wire logic        rx_char_valid,
	output logic             rx_char_accept,
	input  wire logic        rx_buffer_read,
	output logic [8:0]       dmx_first_address,
	output logic [7:0]       lin_tx_byte_count,
	output logic [8:0]       dali_idle_half_bits,
	output logic [7:0]       own_address
);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0]              uart_control_two_q;
	logic                    param_two_high_q;
	logic [7:0]              param_two_low_q;
	logic [1:0]              fifo_count_q;
	logic                    cts_meta_q;
	logic                    cts_sync_q;
	ufc_pkg::ufc_tx_state_e  tx_state_q;

	logic [1:0]              flow_select;
	ufc_pkg::ufc_mode_e      mode;
	logic [8:0]              parameter_two;
	logic                    flow_allowed;
	logic                    hw_flow;
	logic                    wr_en;
	logic                    rd_en;
	logic                    fifo_push;
	logic                    fifo_pop;
	logic                    wr_control;
	logic                    wr_p2_high;
	logic                    wr_p2_low;
	logic [31:0]             status_word;
	logic [31:0]             read_word;
	logic [1:0]              fifo_count_d;
	logic                    rts_n_d;
	logic                    cts_ok;
	ufc_pkg::ufc_tx_state_e  tx_state_d;
	logic                    lde_d;

	// ---------------------------------------------------------------
	// Mode decoding
	// ---------------------------------------------------------------
	// Framed modes run their own line protocol and never use flow control
	function automatic logic is_framed_mode(input ufc_pkg::ufc_mode_e m);
		case (m)
			ufc_pkg::UFC_MODE_LIN_SLV,
			ufc_pkg::UFC_MODE_LIN_MST,
			ufc_pkg::UFC_MODE_DALI,
			ufc_pkg::UFC_MODE_DMX:  is_framed_mode = 1'b1;
			default:                is_framed_mode = 1'b0;
		endcase
	endfunction

	// Parameter two reaches a mode's output only while that mode is selected
	function automatic logic [8:0] param_for(input ufc_pkg::ufc_mode_e m,
		input ufc_pkg::ufc_mode_e owner, input logic [8:0] value);
		param_for = (m == owner) ? value : 9'h000;
	endfunction

	assign flow_select   = uart_control_two_q[`UFC_CTL_FLOW_LSB +: 2];
	assign mode          = ufc_pkg::ufc_mode_e'(uart_control_two_q[`UFC_CTL_MODE_LSB +: 4]);
	assign parameter_two = {param_two_high_q, param_two_low_q};

	assign flow_allowed = !is_framed_mode(mode);
	// XON/XOFF (flow select 01) is accepted but left to software: no pin effect
	assign hw_flow = flow_allowed && (flow_select == `UFC_FLOW_HW);

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !pwrite;

	// Writes land at the access edge; unmapped offsets are ignored
	assign wr_control = wr_en && paddr == `UFC_OFF_CONTROL;
	assign wr_p2_high = wr_en && paddr == `UFC_OFF_P2_HIGH;
	assign wr_p2_low  = wr_en && paddr == `UFC_OFF_P2_LOW;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			uart_control_two_q <= `UFC_RST_CONTROL;
		else if (wr_control)
			uart_control_two_q <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			param_two_high_q <= `UFC_RST_P2_HIGH;
		else if (wr_p2_high)
			param_two_high_q <= pwdata[0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			param_two_low_q <= `UFC_RST_P2_LOW;
		else if (wr_p2_low)
			param_two_low_q <= pwdata[7:0];
	end

	// Status word: fifo count, synced clear-to-send, request-to-send, transmitter busy
	assign status_word = {27'h000_0000, tx_state_q == ufc_pkg::UFC_TX_BUSY, rts_n, cts_sync_q,
		fifo_count_q};

	// Read data is picked in the setup phase and held through the access phase
	always_comb
	begin
		case (paddr)
			`UFC_OFF_CONTROL: read_word = {24'h00_0000, uart_control_two_q};
			`UFC_OFF_P2_HIGH: read_word = {31'h0000_0000, param_two_high_q};
			`UFC_OFF_P2_LOW:  read_word = {24'h00_0000, param_two_low_q};
			`UFC_OFF_STATUS:  read_word = status_word;
			default:          read_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_en && !penable)
			prdata <= read_word;
	end

	// ---------------------------------------------------------------
	// Clear-to-send synchroniser
	// ---------------------------------------------------------------
	// Both flops reset to the released level so no false clearance follows reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cts_meta_q <= 1'b1;
			cts_sync_q <= 1'b1;
		end
		else
		begin
			cts_meta_q <= cts_n_pin;
			cts_sync_q <= cts_meta_q;
		end
	end

	assign cts_ok = !hw_flow || !cts_sync_q;

	// ---------------------------------------------------------------
	// Transmit gating
	// ---------------------------------------------------------------
	// With hardware flow on, a character may start only while the far receiver clears us to send
	assign tx_char_start = (tx_state_q == ufc_pkg::UFC_TX_IDLE) && tx_char_pending && cts_ok;

	// Busy runs from the start edge to the edge that sees done; clear-to-send
	// falling meanwhile does not cut the character short
	always_comb
	begin
		tx_state_d = tx_state_q;
		case (tx_state_q)
			ufc_pkg::UFC_TX_IDLE:
				if (tx_char_start)
					tx_state_d = ufc_pkg::UFC_TX_BUSY;
			ufc_pkg::UFC_TX_BUSY:
				if (tx_char_done)
					tx_state_d = ufc_pkg::UFC_TX_IDLE;
			default:
				tx_state_d = ufc_pkg::UFC_TX_IDLE;
		endcase
	end

	assign lde_d = tx_state_d == ufc_pkg::UFC_TX_BUSY;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_state_q <= ufc_pkg::UFC_TX_IDLE;
		else
			tx_state_q <= tx_state_d;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			line_driver_enable <= 1'b0;
		else
			line_driver_enable <= lde_d;
	end

	// ---------------------------------------------------------------
	// Receive FIFO occupancy and request-to-send
	// ---------------------------------------------------------------
	// Both locations accept regardless of request-to-send
	assign rx_char_accept = fifo_count_q != `UFC_FIFO_DEPTH || rx_buffer_read;
	assign fifo_push      = rx_char_valid && rx_char_accept;
	assign fifo_pop       = rx_buffer_read && fifo_count_q != 2'd0;

	// Occupancy never passes two: a full FIFO takes a character only beside a read
	always_comb
	begin
		case ({fifo_push, fifo_pop})
			2'b10:   fifo_count_d = fifo_count_q + 2'd1;
			2'b01:   fifo_count_d = fifo_count_q - 2'd1;
			default: fifo_count_d = fifo_count_q;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fifo_count_q <= 2'd0;
		else
			fifo_count_q <= fifo_count_d;
	end

	// Request-to-send follows the occupancy after this edge: it rises with the
	// first character taken and falls only once every location is free again
	assign rts_n_d = hw_flow && fifo_count_d != 2'd0;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rts_n <= 1'b1;
		else
			rts_n <= rts_n_d;
	end

	// ---------------------------------------------------------------
	// Parameter two by mode
	// ---------------------------------------------------------------
	// Outputs for modes that are not selected stay at zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dmx_first_address <= 9'h000;
		else
			dmx_first_address <= param_for(mode, ufc_pkg::UFC_MODE_DMX, parameter_two);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lin_tx_byte_count <= 8'h00;
		else
			lin_tx_byte_count <= (mode == ufc_pkg::UFC_MODE_LIN_SLV) ? param_two_low_q
				: 8'h00;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dali_idle_half_bits <= 9'h000;
		else
			dali_idle_half_bits <= param_for(mode, ufc_pkg::UFC_MODE_DALI, parameter_two);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			own_address <= 8'h00;
		else
			own_address <= (mode == ufc_pkg::UFC_MODE_ADDRESS) ? param_two_low_q
				: 8'h00;
	end

endmodule

// >>> tb/ufc_props.sv
`timescale 1ns/1ns
module ufc_props
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic line_driver_enable,
	input wire logic tx_char_pending,
	input wire logic tx_char_done,
	input wire logic tx_char_start,
	input wire logic rts_n,
	input wire logic rx_char_valid,
	input wire logic rx_char_accept
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_apb_ready:
		assert property (pready && !pslverr) else $error("apb answer");
	a_lde_on_start:
		assert property (tx_char_start |=> line_driver_enable) else $error("lde late");
	a_lde_cause:
		assert property ($rose(line_driver_enable) |-> $past(tx_char_start)) else $error("lde cause");
	a_lde_holds:
		assert property (line_driver_enable && !tx_char_done |=> line_driver_enable) else $error("abort");
	a_lde_ends:
		assert property (line_driver_enable && tx_char_done |=> !line_driver_enable) else $error("lde");
	a_one_char:
		assert property (line_driver_enable |-> !tx_char_start) else $error("start in char");
	a_start_pend:
		assert property (tx_char_start |-> tx_char_pending) else $error("start idle");
	a_rts_on_take:
		assert property ($rose(rts_n) |-> $past(rx_char_valid && rx_char_accept)) else $error("rts");
	c_tx: cover property (tx_char_start);
	c_rts: cover property ($rose(rts_n));
	c_full: cover property (rx_char_valid && !rx_char_accept);
endmodule

bind ufc_flow_ctrl ufc_props i_props (.pclk, .presetn, .pready, .pslverr, .line_driver_enable,
	.tx_char_pending, .tx_char_done, .tx_char_start, .rts_n, .rx_char_valid, .rx_char_accept);

// >>> tb/ufc_peer.sv
`timescale 1ns/1ns
module ufc_peer
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic rts_n,
	input  wire logic busy,
	input  wire logic want,
	input  wire logic late,
	output logic      cts_n_pin,
	output logic      rx_char_valid
);
	// Far receiver holds us off by driving its request line high
	assign cts_n_pin = busy;
	// Sends only while cleared, unless a character is already in flight
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			rx_char_valid <= 1'b0;
		else
			rx_char_valid <= want && (!rts_n || late);
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`include "ufc_map.svh"
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, want, late;
	logic        cts_n_pin, rts_n, line_driver_enable, tx_char_pending, tx_char_done;
	logic        tx_char_start, rx_char_valid, rx_char_accept, rx_buffer_read;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic [8:0]  dmx_first_address, dali_idle_half_bits;
	logic [7:0]  lin_tx_byte_count, own_address;
	logic [3:0]  ml [6] = '{4'ha, 4'hb, 4'h8, 4'h4, 4'h0, 4'hc};
	int          errors, num_checks, cnt;

	ufc_flow_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .cts_n_pin, .rts_n, .line_driver_enable, .tx_char_pending,
		.tx_char_done, .tx_char_start, .rx_char_valid, .rx_char_accept, .rx_buffer_read,
		.dmx_first_address, .lin_tx_byte_count, .dali_idle_half_bits, .own_address);
	ufc_peer i_peer (.pclk, .presetn, .rts_n, .busy, .want, .late, .cts_n_pin, .rx_char_valid);

	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (n = 0; n < 20 && pready !== 1'b1; n++)
			@(posedge pclk);
		chk("pready", 1'b1, pready);
		if (n == 20)
			report_and_stop();
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask

	task automatic rdc(input string s, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(s, e, r);
	endtask

	task automatic rxs(input logic [1:0] f, input logic [3:0] m);
		logic hw;
		hw = f == 2'b10 && !(m inside {4'h8, 4'ha, 4'hb, 4'hc});
		wr(`UFC_OFF_CONTROL, {24'h0, m, 2'b00, f});
		chk("rts empty", 1'b0, rts_n);
		repeat (3)
		begin
			@(posedge pclk);
			want <= 1'b1;
			late <= cnt != 0;
			@(posedge pclk);
			want <= 1'b0;
			@(negedge pclk);
			chk("accept", cnt < 2, rx_char_accept);
			cnt += cnt < 2;
			repeat (2) @(posedge pclk);
			chk("rts held", hw, rts_n);
		end
		repeat (2)
		begin
			@(posedge pclk);
			chk("rts read", hw, rts_n);
			rx_buffer_read <= 1'b1;
			@(posedge pclk);
			rx_buffer_read <= 1'b0;
			cnt--;
		end
		repeat (2) @(posedge pclk);
		chk("rts free", 1'b0, rts_n);
	endtask

	task automatic txs;
		int n;
		busy <= 1'b1;
		wr(`UFC_OFF_CONTROL, 32'h2);
		tx_char_pending <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("start held", 1'b0, tx_char_start);
		busy <= 1'b0;
		for (n = 0; n < 9 && tx_char_start !== 1'b1; n++)
			@(negedge pclk);
		chk("start", 1'b1, tx_char_start);
		if (n == 9)
			report_and_stop();
		@(posedge pclk);
		busy <= 1'b1;
		repeat (5) @(posedge pclk);
		chk("lde kept", 1'b1, line_driver_enable);
		tx_char_done <= 1'b1;
		@(posedge pclk);
		tx_char_done <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("lde idle", 1'b0, line_driver_enable);
		chk("no start", 1'b0, tx_char_start);
		busy <= 1'b0;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk("rs485 start", 1'b1, tx_char_start);
		@(posedge pclk);
		tx_char_pending <= 1'b0;
		@(negedge pclk);
		chk("rs485 lde", 1'b1, line_driver_enable);
		@(posedge pclk);
		tx_char_done <= 1'b1;
		@(posedge pclk);
		tx_char_done <= 1'b0;
		@(negedge pclk);
		chk("rs485 end", 1'b0, line_driver_enable);
	endtask

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{tx_char_pending, tx_char_done, rx_buffer_read, busy, want, late} = '0;
		v = $urandom(91);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc("p2 high", `UFC_OFF_P2_HIGH, 32'h0);
		rdc("p2 low", `UFC_OFF_P2_LOW, 32'h0);
		rdc("unmapped", 12'h010, 32'h0);
		foreach (ml[i])
		begin
			v = $urandom;
			wr(`UFC_OFF_P2_HIGH, v >> 8);
			wr(`UFC_OFF_P2_LOW, v);
			wr(`UFC_OFF_CONTROL, {24'h0, ml[i], 4'h0});
			rdc("p2 high", `UFC_OFF_P2_HIGH, {31'h0, v[8]});
			rdc("p2 low", `UFC_OFF_P2_LOW, {24'h0, v[7:0]});
			chk("dmx", ml[i] == 4'ha ? v[8:0] : 9'h0, dmx_first_address);
			chk("lin", ml[i] == 4'hb ? v[7:0] : 8'h0, lin_tx_byte_count);
			chk("dali", ml[i] == 4'h8 ? v[8:0] : 9'h0, dali_idle_half_bits);
			chk("addr", ml[i] == 4'h4 ? v[7:0] : 8'h0, own_address);
		end
		rxs(2'b10, 4'h0);
		rxs(2'b00, 4'h0);
		rxs(2'b01, 4'h0);
		rxs(2'b10, 4'ha);
		rxs(2'b10, 4'hb);
		txs();
		report_and_stop();
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		errors++;
		report_and_stop();
	end
endmodule
